// ===== dv/wfr_far_model.sv
// Far-side model: sample pacing, element pickups, trip and external trigger
`timescale 1ns/1ps
module wfr_far_model
  import wfr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire wfr_frame_s frame_req,
  input wire logic [25:0] pick_req,
  input wire logic ext_req,
  input wire logic trip_req,
  output logic sample_strobe,
  output wfr_frame_s sample_in,
  output logic [25:0] pickup_in,
  output logic external_record_trigger,
  output logic trip_in
);
  initial
  begin
    sample_strobe = 1'b0;
    sample_in = '0;
    pickup_in = '0;
    external_record_trigger = 1'b0;
    trip_in = 1'b0;
  end
  // Levels move only after a sample is taken, as element logic updates once per sample
  always @(posedge sys_clk)
  begin
    sample_strobe <= rst_n && !sample_strobe;
    if (sample_strobe)
    begin
      sample_in <= frame_req;
      pickup_in <= pick_req;
      external_record_trigger <= ext_req;
      trip_in <= trip_req;
    end
  end
endmodule

// ===== dv/wfr_recorder_tb_top.sv
// Self-checking bench for the waveform fault recorder
`timescale 1ns/1ps
`include "wfr_params.svh"
module wfr_recorder_tb_top
  import wfr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic [31:0] time_stamp = 32'h0;
  logic erase_all_records = 1'b0;
  logic logic_reload = 1'b0;
  logic recorder_enable_in = 1'b1;
  logic recording_in_progress;
  logic sample_strobe;
  wfr_frame_s sample_in;
  logic [25:0] pickup_in;
  logic external_record_trigger;
  logic trip_in;
  wfr_frame_s frame_req = '0;
  wfr_frame_s fr;
  logic [25:0] pick_req = 26'h0;
  logic ext_req = 1'b0;
  logic trip_req = 1'b0;
  logic [31:0] seed = 32'h2578;
  logic [31:0] ts_exp;
  logic [14:0] amask = 15'h7fff;
  logic [7:0] dcfg = 8'h00;
  logic ctl_trip = 1'b1;
  int fail_count = 0;
  int checked = 0;
  int m_count = 0;
  int m_next = 0;
  int m_post = 5;
  int m_pre = 5;

  always #2.5 sys_clk = ~sys_clk;

  wfr_recorder u_wfr_recorder (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sample_strobe(sample_strobe),
    .sample_in(sample_in), .time_stamp(time_stamp), .pickup_in(pickup_in),
    .external_record_trigger(external_record_trigger), .trip_in(trip_in),
    .erase_all_records(erase_all_records), .logic_reload(logic_reload),
    .recorder_enable_in(recorder_enable_in), .recording_in_progress(recording_in_progress));

  wfr_far_model u_wfr_far_model (.sys_clk(sys_clk), .rst_n(rst_n), .frame_req(frame_req),
    .pick_req(pick_req), .ext_req(ext_req), .trip_req(trip_req),
    .sample_strobe(sample_strobe), .sample_in(sample_in), .pickup_in(pickup_in),
    .external_record_trigger(external_record_trigger), .trip_in(trip_in));

  // ********
  // Model
  // ********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int slots(int l);
    if (l > 350) return 1;
    if (l > 175) return 2;
    if (l > 22) return `WFR_MAX_CYC / l - 1;
    return (`WFR_MAX_CYC / l > `WFR_MAX_REC) ? `WFR_MAX_REC : `WFR_MAX_CYC / l;
  endfunction

  function automatic logic [31:0] stat_exp();
    return 32'(slots(m_post) << 16 | m_next << 9 | m_count << 1);
  endfunction

  function automatic logic [31:0] lane(wfr_frame_s f, int n);
    logic [319:0] w;
    w = '0;
    w[79:0] = f.digital;
    if (dcfg[2:0] != 3'h0) w[79:64] = dcfg[3] ? f.derived_rms[0] : f.derived[0];
    for (int i = 0; i < `WFR_N_ANA; i++)
      if (amask[i]) w[80 + i * 16 +: 16] = f.analog[i];
    return w[n * 32 +: 32];
  endfunction

  // ********
  // Tasks
  // ********
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rc(string what, logic [7:0] a, logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    // Read data stand only in this cycle; taken at the edge that ends it
    @(posedge sys_clk);
    check(what, rdata, exp);
  endtask

  // Every settings write wipes the store
  task automatic setreg(logic [7:0] a, logic [31:0] d);
    wr(a, d);
    m_count = 0;
    m_next = 0;
  endtask

  task automatic samples(int n);
    repeat (n) @(posedge sys_clk iff sample_strobe);
  endtask

  task automatic wait_rec(logic lvl, int lim);
    int k;
    k = 0;
    while (recording_in_progress !== lvl && k < lim)
    begin
      @(posedge sys_clk);
      k++;
    end
    check("recording_in_progress", 32'(recording_in_progress), 32'(lvl));
  endtask

  task automatic record(logic trip, int k);
    ts_exp = rnd();
    time_stamp <= ts_exp;
    ext_req <= 1'b1;
    wait_rec(1'b1, 20);
    ext_req <= 1'b0;
    time_stamp <= rnd();
    trip_req <= trip;
    if (k > 0)
    begin
      samples(k);
      pick_req <= 26'h1;
      samples(4);
      pick_req <= 26'h0;
    end
    wait_rec(1'b0, 30000);
    trip_req <= 1'b0;
    if (trip || !ctl_trip)
    begin
      if (m_count < slots(m_post)) m_count++;
      m_next = (m_next + 1) % slots(m_post);
    end
  endtask

  task automatic sel_last();
    wr(`WFR_OFS_RSEL, 32'((m_next + slots(m_post) - 1) % slots(m_post)));
  endtask

  task automatic done(string n);
    $display("test %s done", n);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end

  initial
  begin
    logic [479:0] f;
    int pv[11];
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc("ctrl", `WFR_OFS_CTRL, 32'h1);
    rc("pre", `WFR_OFS_PRE, 32'h5);
    rc("post", `WFR_OFS_POST, 32'h5);
    rc("intv", `WFR_OFS_INTV, 32'h4);
    rc("tmask", `WFR_OFS_TMASK, 32'h0800000);
    rc("amask", `WFR_OFS_AMASK, 32'h7fff);
    rc("stat", `WFR_OFS_STAT, stat_exp());
    rc("unmapped", 8'h3c, 32'h0);
    done("reset");
    pv = '{32'h2d5, 32'h15e, 32'haf, 32'h16, 32'hb, 32'h5, 32'h15f, 32'hb0, 32'h17, 32'h4, 32'h320};
    foreach (pv[i])
    begin
      setreg(`WFR_OFS_POST, 32'(pv[i]));
      m_post = pv[i] < `WFR_MIN_POST ? `WFR_MIN_POST : pv[i] > `WFR_MAX_CYC ? `WFR_MAX_CYC : pv[i];
      rc("post", `WFR_OFS_POST, 32'(m_post));
      rc("stat", `WFR_OFS_STAT, stat_exp());
    end
    setreg(`WFR_OFS_PRE, 32'h1e);
    rc("pre", `WFR_OFS_PRE, 32'h19);
    setreg(`WFR_OFS_INTV, 32'h0);
    rc("intv", `WFR_OFS_INTV, 32'h1);
    setreg(`WFR_OFS_INTV, 32'h320);
    rc("intv", `WFR_OFS_INTV, 32'h2d5);
    setreg(`WFR_OFS_POST, 32'h5);
    m_post = 5;
    setreg(`WFR_OFS_PRE, 32'h0);
    m_pre = 0;
    done("settings");
    // Unmasked sources are random noise; the design must stay idle
    repeat (40)
    begin
      pick_req <= 26'(rnd());
      samples(1);
      check("idle", 32'(recording_in_progress), 32'h0);
    end
    pick_req <= 26'h0;
    recorder_enable_in <= 1'b0;
    ext_req <= 1'b1;
    samples(6);
    check("disabled", 32'(recording_in_progress), 32'h0);
    ext_req <= 1'b0;
    samples(3);
    recorder_enable_in <= 1'b1;
    done("mask");
    amask = 15'h7ffd;
    dcfg = 8'h09;
    setreg(`WFR_OFS_AMASK, 32'(amask));
    setreg(`WFR_OFS_DCFG, 32'(dcfg));
    for (int i = 0; i < 15; i++) f[i * 32 +: 32] = rnd();
    fr = wfr_frame_s'(f);
    frame_req <= fr;
    samples(4);
    record(1'b0, 0);
    rc("stat", `WFR_OFS_STAT, stat_exp());
    record(1'b1, 0);
    rc("stat", `WFR_OFS_STAT, stat_exp());
    sel_last();
    for (int n = 0; n < `WFR_LANES; n++)
    begin
      wr(`WFR_OFS_RPTR, 32'(n << 16));
      rc("rdata", `WFR_OFS_RDATA, lane(fr, n));
    end
    rc("ts", `WFR_OFS_ITS, ts_exp);
    rc("len", `WFR_OFS_ILEN, 32'(m_post * `WFR_SPC));
    done("trip");
    erase_all_records <= 1'b1;
    @(posedge sys_clk);
    erase_all_records <= 1'b0;
    m_count = 0;
    m_next = 0;
    rc("stat", `WFR_OFS_STAT, stat_exp());
    ctl_trip = 1'b0;
    setreg(`WFR_OFS_CTRL, 32'h0);
    record(1'b0, 0);
    logic_reload <= 1'b1;
    @(posedge sys_clk);
    logic_reload <= 1'b0;
    m_count = 0;
    m_next = 0;
    rc("stat", `WFR_OFS_STAT, stat_exp());
    record(1'b0, 0);
    setreg(`WFR_OFS_AMASK, 32'h7fff);
    amask = 15'h7fff;
    rc("stat", `WFR_OFS_STAT, stat_exp());
    done("erase");
    setreg(`WFR_OFS_CTRL, 32'h2);
    setreg(`WFR_OFS_TMASK, 32'h0800001);
    setreg(`WFR_OFS_INTV, 32'h1);
    record(1'b0, 10);
    sel_last();
    rc("len_same_fault", `WFR_OFS_ILEN, 32'(m_post * `WFR_SPC));
    record(1'b0, 50);
    sel_last();
    @(posedge sys_clk);
    addr <= `WFR_OFS_ILEN;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(posedge sys_clk);
    check("len_extended", 32'(rdata >= 32'hd0 && rdata <= 32'hd6), 32'h1);
    setreg(`WFR_OFS_CTRL, 32'h0);
    record(1'b0, 50);
    sel_last();
    rc("len_single", `WFR_OFS_ILEN, 32'(m_post * `WFR_SPC));
    done("extend");
    setreg(`WFR_OFS_PRE, 32'h1);
    m_pre = 1;
    samples(40);
    record(1'b0, 0);
    sel_last();
    rc("len_pre", `WFR_OFS_ILEN, 32'((m_pre + m_post) * `WFR_SPC));
    ext_req <= 1'b1;
    wait_rec(1'b1, 20);
    ext_req <= 1'b0;
    samples(10);
    recorder_enable_in <= 1'b0;
    wait_rec(1'b0, 4);
    recorder_enable_in <= 1'b1;
    rc("stat", `WFR_OFS_STAT, stat_exp());
    done("enable");
    setreg(`WFR_OFS_PRE, 32'h0);
    setreg(`WFR_OFS_POST, 32'haf);
    m_post = 175;
    repeat (4)
    begin
      record(1'b0, 0);
      rc("stat", `WFR_OFS_STAT, stat_exp());
    end
    done("wrap");
    finish_test();
  end
endmodule

// ===== hw/wfr_params.svh
// Constants for the waveform fault recorder
`ifndef WFR_PARAMS_SVH
`define WFR_PARAMS_SVH
`define WFR_SPC 32
`define WFR_MAX_CYC 725
`define WFR_MAX_REC 64
`define WFR_MAX_PRE 25
`define WFR_MIN_POST 5
`define WFR_MIN_INTV 1
`define WFR_N_ANA 15
`define WFR_N_DER 5
`define WFR_N_DIG 80
`define WFR_DER_SLOTS 16
`define WFR_N_SRC 26
`define WFR_EXT_BIT 23
`define WFR_WORD_W 320
`define WFR_LANES 10
`define WFR_CLK_HZ 200000000
`define WFR_OFS_CTRL 8'h00
`define WFR_OFS_PRE 8'h04
`define WFR_OFS_POST 8'h08
`define WFR_OFS_INTV 8'h0c
`define WFR_OFS_TMASK 8'h10
`define WFR_OFS_AMASK 8'h14
`define WFR_OFS_DCFG 8'h18
`define WFR_OFS_STAT 8'h1c
`define WFR_OFS_RSEL 8'h20
`define WFR_OFS_RPTR 8'h24
`define WFR_OFS_RDATA 8'h28
`define WFR_OFS_ITS 8'h2c
`define WFR_OFS_ILEN 8'h30
`define WFR_OFS_IHEAD 8'h34
`define WFR_RST_TRIP 1'h1
`define WFR_RST_CONT 1'h0
`define WFR_RST_PRE 5'h05
`define WFR_RST_POST 10'h005
`define WFR_RST_INTV 10'h004
`define WFR_RST_TMASK 26'h0800000
`define WFR_RST_AMASK 15'h7fff
`endif

// ===== hw/wfr_pkg.sv
// Types shared by the waveform fault recorder
package wfr_pkg;
  typedef enum logic {ST_IDLE, ST_REC} wfr_state_e;
  typedef struct packed {
    logic [14:0][15:0] analog;
    logic [4:0][15:0] derived;
    logic [4:0][15:0] derived_rms;
    logic [79:0] digital;
  } wfr_frame_s;
  typedef struct packed {
    logic [31:0] ts;
    logic [14:0] len;
    logic [9:0] head;
    logic [9:0] fill;
  } wfr_info_s;
endpackage

// ===== hw/wfr_recorder.sv
// Waveform fault recorder: trigger, pre-fault ring, cyclic record store, readout
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "wfr_params.svh"
// Contract
// RULE1 - Capture at 32 samples per power cycle, 15 seconds total storage.
// RULE2 - Cyclic store of at most 64 records of analog, derived, digital data.
// RULE3 - Each record keeps samples plus a time stamp of the start.
// RULE4 - Up to 15 analog channels, each with its own enable.
// RULE5 - Up to 5 derived channels, supply voltage among them.
// RULE6 - Sinusoidal derived channels store RMS evolution, not instantaneous samples.
// RULE7 - At most 80 digital channels; each derived channel uses 16 of them.
// RULE8 - A trigger source starts recording only when its mask bit is set.
// RULE9 - Outside logic drives the external trigger from inputs, buttons, commands.
// RULE10 - Delete request erases every stored record.
// RULE11 - With trip required, keep a record only if a trip occurred.
// RULE12 - Continuous mode: new pickup restarts the remaining post-trigger count.
// RULE13 - Pickups inside the inter-trigger interval do not lengthen the record.
// RULE14 - Pickups after the interval extend by record length, only in continuous mode.
// RULE15 - Pre-trigger history of 0 to 25 cycles starts each record.
// RULE16 - When memory is full, a new record overwrites the oldest.
// RULE17 - Total stored length at most 725 cycles, split into slots by length.
// RULE18 - Any settings change or logic reload erases all records.
// RULE19 - Memory zones sized by the record length setting.
// RULE20 - Record length 5 to 725 cycles, interval 1 to 725, step one.
// RULE21 - Recorder works only while its enable input is active.
// RULE22 - Recording-in-progress output is high while a record is captured.
// RULE23 - Start is the OR of masked sources, evaluated once per sample.
// RULE24 - While idle, samples go continuously into a circular pre-trigger buffer.
module wfr_recorder
  import wfr_pkg::*;
#(
  parameter int unsigned MEM_WORDS = `WFR_MAX_CYC * `WFR_SPC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic sample_strobe,
  input wire wfr_frame_s sample_in,
  input wire logic [31:0] time_stamp,
  input wire logic [`WFR_N_SRC-1:0] pickup_in,
  input wire logic external_record_trigger,
  input wire logic trip_in,
  input wire logic erase_all_records,
  input wire logic logic_reload,
  input wire logic recorder_enable_in,
  output logic recording_in_progress
);
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [6:0] slots_for(input logic [9:0] len);
    logic [15:0] q;
    q = 16'(`WFR_MAX_CYC / 32'(len));
    if (len > 10'd350)
      slots_for = 7'd1;
    else if (len > 10'd175)
      slots_for = 7'd2;
    else if (len > 10'd22)
      slots_for = 7'(q - 16'd1);
    else if (q > 16'(`WFR_MAX_REC))
      slots_for = 7'(`WFR_MAX_REC);
    else
      slots_for = 7'(q);
  endfunction

  function automatic logic [9:0] clampv(input logic [31:0] v, input logic [9:0] lo,
                                        input logic [9:0] hi);
    if (v < 32'(lo))
      clampv = lo;
    else if (v > 32'(hi))
      clampv = hi;
    else
      clampv = v[9:0];
  endfunction

  function automatic logic [`WFR_WORD_W-1:0] pack_word(input wfr_frame_s f,
    input logic [14:0] am, input logic [2:0] dn, input logic [4:0] sn);
    logic [79:0] dig;
    logic [239:0] ana;
    dig = f.digital;
    ana = '0;
    for (int i = 0; i < `WFR_N_ANA; i++)
      if (am[i])
        ana[i*16 +: 16] = f.analog[i]; // RULE4
    for (int j = 0; j < `WFR_N_DER; j++)
      if (3'(j) < dn)
        dig[79-`WFR_DER_SLOTS*j -: 16] = sn[j] ? f.derived_rms[j] : f.derived[j]; // RULE5 RULE6 RULE7
    pack_word = {ana, dig};
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic trip_req, cont, next_trip_req, next_cont;
  logic [4:0] pre_cyc, next_pre_cyc;
  logic [9:0] post_cyc, intv_cyc, next_post_cyc, next_intv_cyc;
  logic [25:0] tmask, next_tmask;
  logic [14:0] amask, next_amask;
  logic [2:0] dcnt, next_dcnt;
  logic [4:0] sinus, next_sinus;
  logic [5:0] sel, next_sel;
  logic [14:0] ptr, next_ptr;
  logic [3:0] lane, next_lane;
  logic [31:0] next_rdata;
  wfr_state_e state, next_state;
  logic [5:0] slot, next_slot;
  logic [6:0] cnt, next_cnt;
  logic [14:0] off, next_off, post_left, next_post_left, since, next_since;
  logic [9:0] head, next_head, fill, next_fill;
  logic trip_seen, next_trip_seen;
  logic [25:0] orig, next_orig, prev_g, next_prev_g;
  wfr_info_s cur, next_cur;
  wfr_info_s info [`WFR_MAX_REC];
  logic [`WFR_WORD_W-1:0] mem [MEM_WORDS];

  logic [25:0] srcs, gated, rise;
  logic trig, set_wr, erase, rec_end, keep, extend, mem_we;
  logic [6:0] slots;
  logic [14:0] slot_words, pre_w, post_w, intv_w, waddr, rd_addr;
  wfr_info_s isel;

  always_comb
  begin
    srcs = pickup_in;
    srcs[`WFR_EXT_BIT] = external_record_trigger;
    gated = srcs & tmask; // RULE8
    rise = gated & ~prev_g;
    trig = |gated; // RULE23
    slots = slots_for(post_cyc); // RULE17 RULE19
    slot_words = 15'(MEM_WORDS / 32'(slots));
    pre_w = 15'(pre_cyc) * 15'(`WFR_SPC); // RULE1
    post_w = 15'(post_cyc) * 15'(`WFR_SPC);
    intv_w = 15'(intv_cyc) * 15'(`WFR_SPC);
    set_wr = wr_en && (addr <= `WFR_OFS_DCFG);
    erase = erase_all_records || logic_reload || set_wr; // RULE10 RULE18
    isel = info[sel];
    rd_addr = 15'(sel) * slot_words + ptr;
  end

  // ************************************************************
  // Register bus
  // ************************************************************
  always_comb
  begin
    next_trip_req = trip_req;
    next_cont = cont;
    next_pre_cyc = pre_cyc;
    next_post_cyc = post_cyc;
    next_intv_cyc = intv_cyc;
    next_tmask = tmask;
    next_amask = amask;
    next_dcnt = dcnt;
    next_sinus = sinus;
    next_sel = sel;
    next_ptr = ptr;
    next_lane = lane;
    next_rdata = 32'h0;
    if (wr_en)
    begin
      case (addr)
        `WFR_OFS_CTRL:
        begin
          next_trip_req = wdata[0];
          next_cont = wdata[1];
        end
        `WFR_OFS_PRE: next_pre_cyc = 5'(clampv(wdata, 10'd0, 10'(`WFR_MAX_PRE))); // RULE15
        `WFR_OFS_POST: next_post_cyc = clampv(wdata, 10'(`WFR_MIN_POST),
                                              10'(`WFR_MAX_CYC)); // RULE20
        `WFR_OFS_INTV: next_intv_cyc = clampv(wdata, 10'(`WFR_MIN_INTV),
                                              10'(`WFR_MAX_CYC)); // RULE20
        `WFR_OFS_TMASK: next_tmask = wdata[25:0];
        `WFR_OFS_AMASK: next_amask = wdata[14:0];
        `WFR_OFS_DCFG:
        begin
          next_dcnt = 3'(clampv(32'(wdata[2:0]), 10'd0, 10'(`WFR_N_DER)));
          next_sinus = wdata[7:3];
        end
        `WFR_OFS_RSEL: next_sel = wdata[5:0];
        `WFR_OFS_RPTR:
        begin
          next_ptr = wdata[14:0];
          next_lane = wdata[19:16];
        end
        default: ;
      endcase
    end
    if (rd_en)
    begin
      case (addr)
        `WFR_OFS_CTRL: next_rdata = {30'h0, cont, trip_req};
        `WFR_OFS_PRE: next_rdata = {27'h0, pre_cyc};
        `WFR_OFS_POST: next_rdata = {22'h0, post_cyc};
        `WFR_OFS_INTV: next_rdata = {22'h0, intv_cyc};
        `WFR_OFS_TMASK: next_rdata = {6'h0, tmask};
        `WFR_OFS_AMASK: next_rdata = {17'h0, amask};
        `WFR_OFS_DCFG: next_rdata = {24'h0, sinus, dcnt};
        `WFR_OFS_STAT: next_rdata = {9'h0, slots, 1'h0, slot, 1'h0, cnt,
                                     recording_in_progress};
        `WFR_OFS_RSEL: next_rdata = {26'h0, sel};
        `WFR_OFS_RPTR: next_rdata = {12'h0, lane, 1'h0, ptr};
        `WFR_OFS_RDATA:
          if (32'(rd_addr) < MEM_WORDS && 32'(lane) < `WFR_LANES)
            next_rdata = mem[rd_addr][32'(lane)*32 +: 32];
        `WFR_OFS_ITS: next_rdata = isel.ts;
        `WFR_OFS_ILEN: next_rdata = {17'h0, isel.len};
        `WFR_OFS_IHEAD: next_rdata = {6'h0, isel.fill, 6'h0, isel.head};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      trip_req <= `WFR_RST_TRIP;
      cont <= `WFR_RST_CONT;
      pre_cyc <= `WFR_RST_PRE;
      post_cyc <= `WFR_RST_POST;
      intv_cyc <= `WFR_RST_INTV;
      tmask <= `WFR_RST_TMASK;
      amask <= `WFR_RST_AMASK;
      dcnt <= 3'h0;
      sinus <= 5'h00;
      sel <= 6'h00;
      ptr <= 15'h0000;
      lane <= 4'h0;
      rdata <= 32'h0;
    end
    else
    begin
      trip_req <= next_trip_req;
      cont <= next_cont;
      pre_cyc <= next_pre_cyc;
      post_cyc <= next_post_cyc;
      intv_cyc <= next_intv_cyc;
      tmask <= next_tmask;
      amask <= next_amask;
      dcnt <= next_dcnt;
      sinus <= next_sinus;
      sel <= next_sel;
      ptr <= next_ptr;
      lane <= next_lane;
      rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Capture engine
  // ************************************************************
  always_comb
  begin
    next_state = state;
    next_slot = slot;
    next_cnt = cnt;
    next_off = off;
    next_post_left = post_left;
    next_since = since;
    next_head = head;
    next_fill = fill;
    next_trip_seen = trip_seen;
    next_orig = orig;
    next_prev_g = sample_strobe ? gated : prev_g;
    next_cur = cur;
    rec_end = 1'b0;
    extend = 1'b0;
    keep = 1'b0;
    mem_we = 1'b0;
    waddr = 15'(slot) * slot_words + (state == ST_REC ? off : 15'(head));
    if (erase || !recorder_enable_in) // RULE21
    begin
      // Erase drops any record in flight: its zone layout may have changed
      next_state = ST_IDLE;
      next_head = 10'h000;
      next_fill = 10'h000;
      if (erase)
      begin
        next_cnt = 7'h00;
        next_slot = 6'h00;
      end
    end
    else if (sample_strobe)
    begin
      mem_we = 1'b1;
      case (state)
        ST_IDLE:
          if (trig)
          begin
            // Trigger sample is the first post-trigger word
            next_state = ST_REC;
            next_cur.ts = time_stamp; // RULE3
            next_cur.head = head;
            next_cur.fill = fill;
            next_orig = gated;
            next_trip_seen = trip_in;
            next_post_left = post_w - 15'd1;
            next_since = 15'd1;
            next_off = pre_w + 15'd1;
            waddr = 15'(slot) * slot_words + pre_w;
          end
          else if (pre_w == 15'd0)
            mem_we = 1'b0;
          else
          begin
            next_head = (15'(head) + 15'd1 == pre_w) ? 10'h000 : head + 10'd1; // RULE24
            if (15'(fill) < pre_w)
              next_fill = fill + 10'd1;
          end
        ST_REC:
        begin
          next_off = off + 15'd1;
          next_trip_seen = trip_seen | trip_in;
          next_since = (since == 15'h7fff) ? since : since + 15'd1;
          next_post_left = post_left - 15'd1;
          if ((|(rise & ~orig)) && since >= intv_w && cont) // RULE12 RULE13 RULE14
          begin
            extend = 1'b1;
            next_post_left = post_w;
            next_since = 15'd0;
            next_orig = orig | gated;
          end
          if ((post_left <= 15'd1 && !extend) || off + 15'd1 >= slot_words) // RULE17
          begin
            rec_end = 1'b1;
            keep = !trip_req || trip_seen || trip_in; // RULE11
            next_state = ST_IDLE;
            next_head = 10'h000;
            next_fill = 10'h000;
            if (keep)
            begin
              next_cur.len = off + 15'd1;
              next_slot = (7'(slot) + 7'd1 >= slots) ? 6'h00 : slot + 6'd1; // RULE2 RULE16
              if (cnt < slots)
                next_cnt = cnt + 7'd1;
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      slot <= 6'h00;
      cnt <= 7'h00;
      off <= 15'h0000;
      post_left <= 15'h0000;
      since <= 15'h0000;
      head <= 10'h000;
      fill <= 10'h000;
      trip_seen <= 1'b0;
      orig <= 26'h0;
      prev_g <= 26'h0;
      cur <= '0;
    end
    else
    begin
      state <= next_state;
      slot <= next_slot;
      cnt <= next_cnt;
      off <= next_off;
      post_left <= next_post_left;
      since <= next_since;
      head <= next_head;
      fill <= next_fill;
      trip_seen <= next_trip_seen;
      orig <= next_orig;
      prev_g <= next_prev_g;
      cur <= next_cur;
    end
  end

  // Record store has no reset: stale contents are hidden by the record count
  always_ff @(posedge sys_clk)
  begin
    if (mem_we && 32'(waddr) < MEM_WORDS)
      mem[waddr] <= pack_word(sample_in, amask, dcnt, sinus); // RULE1
    if (rst_n && rec_end && keep && !erase && recorder_enable_in)
      info[slot] <= '{ts: cur.ts, len: off + 15'd1, head: cur.head, fill: cur.fill};
  end

  assign recording_in_progress = (state == ST_REC); // RULE22

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  trig_start_a: assert property (state == ST_IDLE && sample_strobe && |(srcs & tmask)
    && !erase && recorder_enable_in |=> recording_in_progress) // RULE8
    else $error("masked trigger did not start a record");
  no_trig_a: assert property (state == ST_IDLE && !(|(srcs & tmask)) |=>
    !recording_in_progress) // RULE23
    else $error("record started with no masked source");
  erase_cnt_a: assert property (erase_all_records |=> cnt == 7'h00 && slot == 6'h00) // RULE10
    else $error("delete request left records");
  reload_a: assert property (logic_reload || set_wr |=> cnt == 7'h00
    && !recording_in_progress) // RULE18
    else $error("settings change or reload did not erase");
  cnt_max_a: assert property (cnt <= slots && 7'(slot) < slots) // RULE16
    else $error("record count beyond slot count");
  disable_a: assert property (!recorder_enable_in |=> !recording_in_progress) // RULE21
    else $error("recording while disabled");
  trip_drop_a: assert property (rec_end && trip_req && !trip_seen && !trip_in |=>
    $stable(cnt) && $stable(slot)) // RULE11
    else $error("untripped record was kept");
  extend_a: assert property (extend |=> post_left == 15'(post_cyc) * 15'd32) // RULE14
    else $error("extension did not reload record length");
  no_ext_a: assert property (state == ST_REC && sample_strobe && since < intv_w
    && !erase && recorder_enable_in |=> post_left == $past(post_left) - 15'd1) // RULE13
    else $error("pickup inside interval lengthened record");
  slot_len_a: assert property (post_cyc > 10'd350 |-> slots == 7'd1) // RULE17
    else $error("long record must own all memory");
  hold_a: assert property (recording_in_progress && !sample_strobe && !erase
    && recorder_enable_in |=> recording_in_progress [*1]) // RULE22
    else $error("record dropped without a sample");

  rec_cov_c: cover property (recording_in_progress ##1 rec_end);
  ext_cov_c: cover property (extend);
  drop_cov_c: cover property (rec_end && !keep);
  wrap_cov_c: cover property (cnt == slots && rec_end && keep);
endmodule
